// File: dv/aux_requester_model.sv
// Auxiliary requesters sharing the store: each holds its request until served.
// Assumes the arbiter pulses one done bit per granted access.
`timescale 1ns/1ps
`default_nettype none
`include "core_arbiter_consts.vh"
module aux_requester_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`AUX_COUNT-1:0] raise,
    input wire logic [`AUX_COUNT-1:0] done,
    output logic [`AUX_COUNT-1:0] req,
    output logic [`AUX_COUNT-1:0] write,
    output logic [`AUX_COUNT*`CORE_ADDR_W-1:0] addr,
    output logic [`AUX_COUNT*`CORE_DATA_W-1:0] wdata
);
    // fixed locations.
    // Even requesters write a result, odd ones read the neighbour's location.
    assign write = 6'h15;
    for (genvar i = 0; i < `AUX_COUNT; i++) begin : g_slot
        assign addr[i*`CORE_ADDR_W +: `CORE_ADDR_W] = 11'h100 | 11'(i & 6);
        assign wdata[i*`CORE_DATA_W +: `CORE_DATA_W] = 24'hA00000 | 24'(i);
    end
    always @(posedge clk) begin
        if (rst) begin
            req <= 6'h00;
        end else begin
            req <= (req | raise) & ~done;
        end
    end
endmodule // aux_requester_model
`default_nettype wire

// File: dv/core_arbiter_properties.sv
// Port-level checks for the core store access arbiter.
// Assumes one clock CLK and a synchronous, active-high RST.
`timescale 1ns/1ps
`default_nettype none
`include "core_arbiter_consts.vh"
module core_arbiter_properties #(
    parameter AUX_N = `AUX_COUNT
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic MAIN_VALID,
    input wire logic [`OP_W-1:0] MAIN_OP,
    input wire logic MAIN_DONE,
    input wire logic [AUX_N-1:0] AUX_REQ,
    input wire logic [AUX_N-1:0] AUX_GRANT,
    input wire logic [AUX_N-1:0] AUX_DONE,
    input wire logic CYCLE_START,
    input wire logic [`OWN_W-1:0] OWNER
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    wire main_acc = MAIN_VALID && (MAIN_OP <= `OP_BOOL_LOGIC);
    wire any_done = MAIN_DONE || (|AUX_DONE);
    AST_GRANT_ONEHOT: assert property ($onehot0(AUX_GRANT))
        else $error("Two grants at once.");
    AST_ONE_ACCESS: assert property (any_done |=> !any_done [*4])
        else $error("Second access in one cycle.");
    AST_MAIN_WINS: assert property (
        CYCLE_START && main_acc |-> ##4 (MAIN_DONE && AUX_DONE == 0))
        else $error("Main access lost its cycle.");
    AST_HOLE_TO_AUX: assert property (
        CYCLE_START && !main_acc && (|AUX_REQ) |-> ##4 ((|AUX_DONE) && !MAIN_DONE))
        else $error("Free cycle not given to auxiliary.");
    AST_AUX_ORDER: assert property (
        (|AUX_DONE) |-> AUX_DONE == ($past(AUX_REQ, 4) & (~$past(AUX_REQ, 4) + 1'b1)))
        else $error("Auxiliary priority order broken.");
    AST_DONE_FROM_GRANT: assert property ((|AUX_DONE) |-> AUX_DONE == $past(AUX_GRANT))
        else $error("Done on a requester not granted.");
    AST_OWNER_FREE: assert property (any_done |-> OWNER == `OWN_NONE)
        else $error("Owner kept after completion.");
    AST_OWNER_MAIN: assert property (
        $rose(OWNER == `OWN_MAIN) |-> AUX_GRANT == 0 ##3 MAIN_DONE)
        else $error("Main ownership without main completion.");
    COV_MAIN: cover property (MAIN_DONE);
    COV_LAST_AUX: cover property (AUX_DONE[AUX_N-1]);
    COV_CONTEND: cover property (CYCLE_START && main_acc && (|AUX_REQ));
endmodule // core_arbiter_properties
bind core_memory_access_arbiter core_arbiter_properties #(.AUX_N(AUX_N)) props (
    .CLK(CLK), .RST(RST), .MAIN_VALID(MAIN_VALID), .MAIN_OP(MAIN_OP),
    .MAIN_DONE(MAIN_DONE), .AUX_REQ(AUX_REQ), .AUX_GRANT(AUX_GRANT),
    .AUX_DONE(AUX_DONE), .CYCLE_START(CYCLE_START), .OWNER(OWNER));
`default_nettype wire

// File: dv/tb_core_memory_access_arbiter.sv
// Self-checking bench for the core store arbiter, one row per machine cycle.
// Assumes a shortened machine cycle of 8 clocks.
`timescale 1ns/1ps
`default_nettype none
`include "core_arbiter_consts.vh"
module tb_core_memory_access_arbiter;
    typedef struct packed {
        logic v;
        logic [3:0] op;
        logic [10:0] a;
        logic [23:0] wd;
        logic bw;
        logic [5:0] req;
        logic [5:0] ad;
        logic [1:0] ck;
        logic [23:0] rd;
    } row_t;
    logic CLK, RST, MAIN_VALID, MAIN_BOOL_WDATA, MAIN_DONE, MAIN_BOOL_RDATA, CYCLE_START;
    logic [3:0] MAIN_OP;
    logic [10:0] MAIN_ADDR;
    logic [23:0] MAIN_WDATA, MAIN_RDATA, AUX_RDATA;
    logic [5:0] AUX_REQ, AUX_WRITE, AUX_GRANT, AUX_DONE, raise;
    logic [65:0] AUX_ADDR;
    logic [143:0] AUX_WDATA;
    logic [2:0] OWNER;
    integer n_errors = 0;
    integer checks_done = 0;
    integer n, k;
    row_t rows [0:17] = '{
        '{1, 4'h1, 11'h7FF, 24'h800001, 0, 6'h00, 6'h00, 0, 0},
        '{1, 4'h2, 11'h7FF, 0, 0, 6'h3F, 6'h00, 1, 24'h800001},
        '{1, 4'hE, 0, 0, 0, 0, 6'h01, 0, 0}, '{1, 4'h8, 0, 0, 0, 0, 6'h02, 0, 0},
        '{1, 4'h9, 0, 0, 0, 0, 6'h04, 0, 0}, '{1, 4'hA, 0, 0, 0, 0, 6'h08, 0, 0},
        '{1, 4'hB, 0, 0, 0, 0, 6'h10, 0, 0}, '{1, 4'hC, 0, 0, 0, 0, 6'h20, 0, 0},
        '{1, 4'hD, 0, 0, 0, 0, 6'h00, 0, 0}, '{0, 4'h0, 0, 0, 0, 6'h01, 6'h01, 0, 0},
        '{1, 4'h1, 11'h005, 24'h7FFFF0, 0, 0, 0, 0, 0},
        '{1, 4'h4, 11'h053, 0, 1, 0, 0, 0, 0},
        '{1, 4'h0, 11'h005, 0, 0, 0, 0, 1, 24'h7FFFF8},
        '{1, 4'h4, 11'h05F, 0, 0, 0, 0, 0, 0}, '{1, 4'h3, 11'h05F, 0, 0, 0, 0, 2, 0},
        '{1, 4'h5, 11'h054, 0, 0, 0, 0, 2, 1},
        '{1, 4'h1, 11'h07F, 24'h000001, 0, 0, 0, 0, 0},
        '{1, 4'h3, 11'h7F0, 0, 0, 0, 0, 2, 1}};
    core_memory_access_arbiter #(.CYCLE_CLKS(8)) uut (
        .CLK(CLK), .RST(RST), .MAIN_VALID(MAIN_VALID), .MAIN_OP(MAIN_OP),
        .MAIN_ADDR(MAIN_ADDR), .MAIN_WDATA(MAIN_WDATA), .MAIN_BOOL_WDATA(MAIN_BOOL_WDATA),
        .MAIN_DONE(MAIN_DONE), .MAIN_RDATA(MAIN_RDATA), .MAIN_BOOL_RDATA(MAIN_BOOL_RDATA),
        .AUX_REQ(AUX_REQ), .AUX_WRITE(AUX_WRITE), .AUX_ADDR(AUX_ADDR),
        .AUX_WDATA(AUX_WDATA), .AUX_GRANT(AUX_GRANT), .AUX_DONE(AUX_DONE),
        .AUX_RDATA(AUX_RDATA), .CYCLE_START(CYCLE_START), .OWNER(OWNER));
    aux_requester_model partner (.clk(CLK), .rst(RST), .raise(raise), .done(AUX_DONE),
        .req(AUX_REQ), .write(AUX_WRITE), .addr(AUX_ADDR), .wdata(AUX_WDATA));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task automatic finish_test;
        begin
            if (n_errors == 0 && checks_done > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    task automatic check_idle;
        begin
            @(negedge CLK);
            check({MAIN_DONE, AUX_GRANT, AUX_DONE, CYCLE_START}, 0);
            check(OWNER, `OWN_NONE);
        end
    endtask
    // Drive one machine cycle, then watch its completion window.
    task automatic run_row(input row_t r);
        integer i;
        logic md;
        logic mbd;
        logic [5:0] ad;
        logic [23:0] mrd, ard;
        logic [2:0] own, eo;
        begin
            @(posedge CLK);
            MAIN_VALID <= r.v;
            MAIN_OP <= r.op;
            MAIN_ADDR <= r.a;
            MAIN_WDATA <= r.wd;
            MAIN_BOOL_WDATA <= r.bw;
            raise <= r.req;
            @(posedge CLK);
            raise <= 6'h00;
            i = 0;
            @(negedge CLK);
            while (CYCLE_START !== 1'b1 && i < 40) begin
                @(negedge CLK);
                i = i + 1;
            end
            md = 0;
            ad = 0;
            @(negedge CLK);
            own = OWNER;
            repeat (4) begin
                @(negedge CLK);
                if (MAIN_DONE === 1'b1) begin
                    md = 1;
                    mrd = MAIN_RDATA;
                    mbd = MAIN_BOOL_RDATA;
                end
                ad = ad | AUX_DONE;
                ard = (|AUX_DONE) ? AUX_RDATA : ard;
            end
            check(md, r.v && r.op <= `OP_BOOL_LOGIC);
            check(ad, r.ad);
            if (r.ck[0]) check(mrd, r.rd);
            if (r.ck[1]) check(mbd, r.rd[0]);
            for (i = 1; i < 6; i = i + 2) begin
                if (r.ad[i]) check(ard, 24'hA00000 | 24'(i - 1));
            end
            eo = `OWN_NONE;
            for (i = 5; i >= 0; i = i - 1) begin
                if (r.ad[i]) eo = i[2:0];
            end
            if (r.v && r.op <= `OP_BOOL_LOGIC) eo = `OWN_MAIN;
            check(own, eo);
        end
    endtask
    initial begin
        CLK = 0;
        forever #2 CLK = ~CLK;
    end
    initial begin
        #20000;
        n_errors = n_errors + 1;
        finish_test;
    end
    initial begin
        RST = 1;
        {MAIN_VALID, MAIN_OP, MAIN_ADDR, MAIN_WDATA, MAIN_BOOL_WDATA, raise} = 0;
        repeat (16) @(posedge CLK);
        check_idle;
        @(posedge CLK);
        RST <= 0;
        for (n = 0; n < 18; n = n + 1) run_row(rows[n]);
        // Reset in mid-run while every requester is pending.
        @(posedge CLK);
        MAIN_VALID <= 0;
        raise <= 6'h3F;
        @(posedge CLK);
        raise <= 6'h00;
        k = 0;
        while (AUX_GRANT === 6'h00 && k < 20) begin
            @(negedge CLK);
            k = k + 1;
        end
        @(posedge CLK);
        RST <= 1;
        @(posedge CLK);
        check_idle;
        @(posedge CLK);
        RST <= 0;
        run_row(rows[9]);
        finish_test;
    end
endmodule // tb_core_memory_access_arbiter
`default_nettype wire

// File: include/core_arbiter_consts.vh
// Constants for the core store and its access arbiter.
// Included by the arbiter and the store module; definitions only.
`ifndef CORE_ARBITER_CONSTS_VH
`define CORE_ARBITER_CONSTS_VH

// Store geometry.
`define CORE_WORDS 2048
`define CORE_ADDR_W 11
`define CORE_DATA_W 24
`define CORE_SIGN_BIT 23
`define BOOL_WORDS 128
`define BOOL_WORD_ADDR_W 7
`define BOOL_BITS_PER_WORD 16
`define BOOL_BIT_SEL_W 4

// Machine cycle, in picoseconds, and the clock period.
`define MACHINE_CYCLE_PS 6105000
`define CLK_PERIOD_PS 4000
`define MACHINE_CYCLE_CLKS (`MACHINE_CYCLE_PS / `CLK_PERIOD_PS)

// Main program operation classes.
`define OP_W 4
`define OP_LOAD 4'h0
`define OP_STORE 4'h1
`define OP_ARITH 4'h2
`define OP_BOOL_LOAD 4'h3
`define OP_BOOL_STORE 4'h4
`define OP_BOOL_LOGIC 4'h5
`define OP_SCALE 4'h8
`define OP_SHIFT 4'h9
`define OP_ABS 4'hA
`define OP_INVERT 4'hB
`define OP_ZERO_SLICE 4'hC
`define OP_FLAG 4'hD
`define OP_NOP 4'hE

// Auxiliary requester indices, highest priority first.
`define AUX_COUNT 6
`define AUX_INTERP 0
`define AUX_PRESEL 1
`define AUX_AIN 2
`define AUX_AOUT 3
`define AUX_BIN 4
`define AUX_BOUT 5

// Grant owner codes.
`define OWN_W 3
`define OWN_NONE 3'h7
`define OWN_MAIN 3'h6

`endif

// File: verilog/core_memory_access_arbiter.v
// Core working store with the machine-cycle access arbiter in front of it.
// Assumes requesters are synchronous to CLK and hold requests until granted.
//
// Functional notes
// - Store holds 2048 addressable words, each readable or writable on command.
// - At most one word access per machine cycle, shared by all requesters.
// - Words are 24 bits; the top bit is the sign.
// - Every location may be overwritten or cleared at any time.
// - A main program access always wins the cycle.
// - A cycle without main program access goes to a waiting auxiliary requester.
// - Scale, shift, abs, invert, zero slice, flag and no-op free the cycle.
// - Auxiliary order: interpolator, preselector, analog in, analog out, Boolean in, out.
// - Words 0 to 127 also form the Boolean region.
// - Low 16 bits of those words give 2048 single Boolean bits.
// - A main Boolean access is a real word access with top priority.
// - Ordinary instructions may still move a whole Boolean-region word.
// - Inputs go to and outputs come from fixed store locations.
// - One main instruction per 6.105 us machine cycle sets the arbitration rate.
`timescale 1ns/1ps
`default_nettype none
`include "core_arbiter_consts.vh"

module core_memory_access_arbiter #(
    parameter CYCLE_CLKS = `MACHINE_CYCLE_CLKS,
    parameter AUX_N = `AUX_COUNT
) (
    input wire CLK,
    input wire RST,
    // Main program unit request, sampled at the start of each machine cycle.
    input wire MAIN_VALID,
    input wire [`OP_W-1:0] MAIN_OP,
    input wire [`CORE_ADDR_W-1:0] MAIN_ADDR,
    input wire [`CORE_DATA_W-1:0] MAIN_WDATA,
    input wire MAIN_BOOL_WDATA,
    output reg MAIN_DONE,
    output reg [`CORE_DATA_W-1:0] MAIN_RDATA,
    output reg MAIN_BOOL_RDATA,
    // Auxiliary requesters, one bit or one field each, index 0 highest.
    input wire [AUX_N-1:0] AUX_REQ,
    input wire [AUX_N-1:0] AUX_WRITE,
    input wire [AUX_N*`CORE_ADDR_W-1:0] AUX_ADDR,
    input wire [AUX_N*`CORE_DATA_W-1:0] AUX_WDATA,
    output reg [AUX_N-1:0] AUX_GRANT,
    output reg [AUX_N-1:0] AUX_DONE,
    output reg [`CORE_DATA_W-1:0] AUX_RDATA,
    // Cycle boundary marker and current owner.
    output reg CYCLE_START,
    output reg [`OWN_W-1:0] OWNER
);
    // Wide enough for a full machine cycle; CYCLE_CLKS must be 5 or more.
    localparam CW = 13;
    localparam integer LAST_INT = CYCLE_CLKS - 1;
    localparam [CW-1:0] LAST_CLK = LAST_INT[CW-1:0];
    // Access pipeline: grant, store read, store write, completion.
    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_MERGE = 2'h2;
    localparam ST_FINISH = 2'h3;

    reg [CW-1:0] cyc_cnt;
    reg [1:0] state;
    // Winner of the coming cycle, worked out combinationally.
    reg [`OWN_W-1:0] next_owner;
    reg [AUX_N-1:0] next_grant;
    reg main_mem;
    reg main_bool;
    reg main_write;
    reg next_write;
    reg [`CORE_ADDR_W-1:0] next_addr;
    reg [`CORE_DATA_W-1:0] next_wdata;

    // Latched access for the running cycle.
    reg acc_write;
    reg acc_bool;
    reg [`CORE_ADDR_W-1:0] acc_addr;
    reg [`BOOL_BIT_SEL_W-1:0] acc_bit;
    reg [`CORE_DATA_W-1:0] acc_wdata;
    reg acc_bool_bit;

    // Store port, driven by the pipeline state.
    reg st_access;
    reg st_write;
    reg [`CORE_ADDR_W-1:0] st_addr;
    reg [`CORE_DATA_W-1:0] st_wdata;
    wire [`CORE_DATA_W-1:0] st_rdata;

    // Loop index of the priority scan.
    integer i;

    // Classify the main program operation.
    always @* begin
        main_mem = 1'b0;
        main_bool = 1'b0;
        main_write = 1'b0;
        case (MAIN_OP)
            `OP_LOAD: begin
                main_mem = 1'b1;
            end
            `OP_ARITH: begin
                main_mem = 1'b1;
            end
            `OP_STORE: begin
                main_mem = 1'b1;
                main_write = 1'b1;
            end
            `OP_BOOL_LOAD: begin
                main_mem = 1'b1;
                main_bool = 1'b1;
            end
            `OP_BOOL_LOGIC: begin
                main_mem = 1'b1;
                main_bool = 1'b1;
            end
            `OP_BOOL_STORE: begin
                main_mem = 1'b1;
                main_bool = 1'b1;
                main_write = 1'b1;
            end
            default: begin
                main_mem = 1'b0;
            end
        endcase
        // With no instruction present the cycle is a hole as well.
        if (!MAIN_VALID) begin
            main_mem = 1'b0;
        end
    end

    // Pick the owner of the coming cycle.
    always @* begin
        next_owner = `OWN_NONE;
        next_grant = {AUX_N{1'b0}};
        next_write = 1'b0;
        next_addr = {`CORE_ADDR_W{1'b0}};
        next_wdata = {`CORE_DATA_W{1'b0}};
        if (main_mem) begin
            next_owner = `OWN_MAIN;
            next_write = main_write;
            next_addr = MAIN_ADDR;
            next_wdata = MAIN_WDATA;
        end else begin
            // fixed priority
            // Scanning from the lowest priority up lets index 0 win.
            for (i = AUX_N - 1; i >= 0; i = i - 1) begin
                if (AUX_REQ[i]) begin
                    next_owner = i[`OWN_W-1:0];
                    next_grant = {AUX_N{1'b0}};
                    next_grant[i] = 1'b1;
                    next_write = AUX_WRITE[i];
                    next_addr = AUX_ADDR[i*`CORE_ADDR_W +: `CORE_ADDR_W];
                    next_wdata = AUX_WDATA[i*`CORE_DATA_W +: `CORE_DATA_W];
                end
            end
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            cyc_cnt <= {CW{1'b0}};
            CYCLE_START <= 1'b0;
        end else begin
            // CYCLE_START marks the first clock of each machine cycle except the first one after reset.
            CYCLE_START <= (cyc_cnt == LAST_CLK);
            if (cyc_cnt == LAST_CLK) begin
                cyc_cnt <= {CW{1'b0}};
            end else begin
                cyc_cnt <= cyc_cnt + 1'b1;
            end
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            state <= ST_IDLE;
            OWNER <= `OWN_NONE;
            AUX_GRANT <= {AUX_N{1'b0}};
            AUX_DONE <= {AUX_N{1'b0}};
            MAIN_DONE <= 1'b0;
            MAIN_RDATA <= {`CORE_DATA_W{1'b0}};
            MAIN_BOOL_RDATA <= 1'b0;
            AUX_RDATA <= {`CORE_DATA_W{1'b0}};
            acc_write <= 1'b0;
            acc_bool <= 1'b0;
            acc_addr <= {`CORE_ADDR_W{1'b0}};
            acc_bit <= {`BOOL_BIT_SEL_W{1'b0}};
            acc_wdata <= {`CORE_DATA_W{1'b0}};
            acc_bool_bit <= 1'b0;
        end else begin
            MAIN_DONE <= 1'b0;
            AUX_DONE <= {AUX_N{1'b0}};
            case (state)
                ST_IDLE: begin
                    // Requests are looked at only on the first clock of a machine cycle.
                    if (cyc_cnt == {CW{1'b0}} && next_owner != `OWN_NONE) begin
                        OWNER <= next_owner;
                        AUX_GRANT <= next_grant;
                        acc_write <= next_write;
                        acc_bool <= main_mem & main_bool;
                        acc_wdata <= next_wdata;
                        acc_bool_bit <= MAIN_BOOL_WDATA;
                        // A Boolean access splits its address into word 0 to 127 and a bit.
                        // Boolean region words
                        if (main_mem && main_bool) begin
                            acc_addr <= {{(`CORE_ADDR_W-`BOOL_WORD_ADDR_W){1'b0}},
                                MAIN_ADDR[`CORE_ADDR_W-1:`BOOL_BIT_SEL_W]};
                            acc_bit <= MAIN_ADDR[`BOOL_BIT_SEL_W-1:0];
                        end else begin
                            acc_addr <= next_addr;
                            acc_bit <= {`BOOL_BIT_SEL_W{1'b0}};
                        end
                        state <= ST_READ;
                    end else if (cyc_cnt == {CW{1'b0}}) begin
                        OWNER <= `OWN_NONE;
                        AUX_GRANT <= {AUX_N{1'b0}};
                    end
                end
                ST_READ: begin
                    // The store reads the addressed word during this state, except on a plain (non-Boolean) write.
                    state <= ST_MERGE;
                end
                ST_MERGE: begin
                    // Writes, the merged Boolean word included, land at the end of this state.
                    state <= ST_FINISH;
                end
                ST_FINISH: begin
                    // Completion pulse and read data go out together; the owner is released.
                    if (OWNER == `OWN_MAIN) begin
                        MAIN_DONE <= 1'b1;
                        // For a plain store this holds the last word read.
                        MAIN_RDATA <= st_rdata;
                        MAIN_BOOL_RDATA <= st_rdata[acc_bit];
                    end else begin
                        AUX_DONE <= AUX_GRANT;
                        AUX_RDATA <= st_rdata;
                    end
                    AUX_GRANT <= {AUX_N{1'b0}};
                    OWNER <= `OWN_NONE;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // one access per cycle
    // Boolean stores are read-modify-write on the same word, still one word access.
    always @* begin
        st_access = 1'b0;
        st_write = 1'b0;
        st_addr = acc_addr;
        st_wdata = acc_wdata;
        case (state)
            ST_READ: begin
                st_access = acc_bool | ~acc_write;
            end
            ST_MERGE: begin
                st_access = acc_write;
                st_write = acc_write;
                if (acc_bool) begin
                    st_wdata = st_rdata;
                    st_wdata[acc_bit] = acc_bool_bit;
                end
            end
            default: begin
                st_access = 1'b0;
            end
        endcase
    end

    // The store itself has no reset; its words are unknown until written.
    // 2048 words
    core_word_store #(
        .DEPTH(`CORE_WORDS),
        .AW(`CORE_ADDR_W),
        .DW(`CORE_DATA_W)
    ) u_store (
        .clk(CLK),
        .access(st_access),
        .write(st_write),
        .addr(st_addr),
        .wdata(st_wdata),
        .rdata(st_rdata)
    );
endmodule // core_memory_access_arbiter

`default_nettype wire

// File: verilog/core_word_store.v
// Single-port word store: one read or write per access strobe.
// Assumes the arbiter issues at most two strobes per machine cycle, a read then a write for a Boolean store.
`timescale 1ns/1ps
`default_nettype none
`include "core_arbiter_consts.vh"

module core_word_store #(
    parameter DEPTH = `CORE_WORDS,
    parameter AW = `CORE_ADDR_W,
    parameter DW = `CORE_DATA_W
) (
    input wire clk,
    input wire access,
    input wire write,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:DEPTH-1];

    always @(posedge clk) begin
        if (access && write) begin
            mem[addr] <= wdata;
        end
        if (access && !write) begin
            rdata <= mem[addr];
        end
    end
endmodule // core_word_store

`default_nettype wire
